/* src/tfu_pkg.sv */
// Purpose: shared constants of the tdm frame timing unit
// Assumes: one 10 MHz system clock; all pins sampled on it
// Notes: frame timing counts in half periods of the reference clock
package tfu_pkg;
   localparam int SYS_CLK_NS = 100;
   localparam int REF_CLK_KHZ = 8192;
   localparam int HALF_TICK_NS = 61;
   // pulse widths as printed, in ns
   localparam int BASE_NARROW_NS = 122;
   localparam int BASE_WIDE_NS = 244;
   localparam int DBL_NARROW_NS = 61;
   localparam int DBL_WIDE_NS = 122;
   // widths in half ticks of the reference clock
   localparam logic [2:0] BASE_NARROW_HT = 3'(BASE_NARROW_NS / HALF_TICK_NS);
   localparam logic [2:0] BASE_WIDE_HT = 3'(BASE_WIDE_NS / HALF_TICK_NS);
   localparam logic [2:0] DBL_NARROW_HT = 3'(DBL_NARROW_NS / HALF_TICK_NS);
   localparam logic [2:0] DBL_WIDE_HT = 3'(DBL_WIDE_NS / HALF_TICK_NS);
   // input frame pulse width in reference periods
   localparam logic [1:0] FP_IN_NARROW_REF = 2'h1;
   localparam logic [1:0] FP_IN_WIDE_REF = 2'h2;
   // frame geometry: 1024 reference periods, 4 bits per period
   localparam int HT_BITS = 11;
   localparam logic [HT_BITS-1:0] HT_LAST = 11'h7ff;
   localparam int BITS_PER_REF = 4;
   localparam int CHAN_BITS = 9;
   localparam int STREAMS = 8;
   // idle-level samples needed to decide the frame pulse style
   localparam logic [2:0] IDLE_LOCK_CNT = 3'h7;
endpackage : tfu_pkg

/* src/tfu_lane.sv */
// Purpose: one serial stream lane: nibble-to-byte receive, byte-to-nibble send
// Assumes: four stream bits arrive per reference period, msb first
// Notes: a channel spans two reference periods
`timescale 1ns/1ps
module tfu_lane (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic tick_i,
   input wire logic first_i,
   input wire logic [3:0] ser_i,
   input wire logic [7:0] tx_byte_i,
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o,
   output logic [3:0] ser_o
);
   logic [3:0] hi_r;
   logic [3:0] tx_lo_r;

   // receive: first nibble held, second completes the channel byte
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hi_r <= 4'h0;
         rx_byte_o <= 8'h00;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (tick_i && first_i) begin
            hi_r <= ser_i;
         end else if (tick_i) begin
            rx_byte_o <= {hi_r, ser_i};
            rx_valid_o <= 1'b1;
         end
      end
   end

   // send: whole byte taken at channel start so it cannot tear mid-channel
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_lo_r <= 4'h0;
         ser_o <= 4'h0;
      end else if (tick_i && first_i) begin
         ser_o <= tx_byte_i[7:4];
         tx_lo_r <= tx_byte_i[3:0];
      end else if (tick_i) begin
         ser_o <= tx_lo_r;
      end
   end

   // bounded form: ticks one reference period apart, as the source makes them
   a_rx_pairing: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (tick_i && first_i) ##1 (!tick_i) [*3] ##1 (tick_i && !first_i)
      |=> rx_valid_o && rx_byte_o == {$past(ser_i, 5), $past(ser_i)})
      else $error("rx byte not paired from two nibbles");
endmodule : tfu_lane

/* src/tfu_timing.sv */
// Purpose: frame and clock timing of a 32.768 Mbps time-slot switch
// Assumes: ref clock, frame pulse and stream nibbles are synchronous samples
// Notes: generated clocks are modelled as levels and one-cycle ticks
//
// Contract
// - the internal frame boundary sits on the rising or falling reference edge per input_edge_select.
// - the input frame pulse is 122 ns wide when pulse_width_select is low, else 244 ns.
// - native or gci frame pulse style is detected with no setting.
// - the base output clock edge chosen by output_edge_select marks the output frame boundary.
// - the base output frame pulse is 122 ns wide when pulse_width_select is low, else 244 ns.
// - both output frame pulses repeat at 8 kHz in the detected input style.
// - serial output data is aligned to the base output clock and frame pulse.
// - a 16.384 MHz output clock is made, aligned to the double-rate frame boundary.
// - the double-rate frame pulse is 61 ns wide when pulse_width_select is low, else 122 ns.
// - eight backplane input streams of 512 channels are accepted.
// - eight local input streams of 512 channels are accepted.
// - eight backplane and eight local output streams of 512 channels are driven.
`timescale 1ns/1ps
module tfu_timing (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ref_clock_in_i,
   input wire logic frame_pulse_in_i,
   input wire logic input_edge_select_i,
   input wire logic output_edge_select_i,
   input wire logic pulse_width_select_i,
   input wire logic [31:0] backplane_serial_in_i,
   input wire logic [31:0] local_serial_in_i,
   input wire logic [63:0] backplane_tx_byte_i,
   input wire logic [63:0] local_tx_byte_i,
   output logic base_clock_out_o,
   output logic base_frame_out_o,
   output logic double_clock_out_o,
   output logic double_frame_out_o,
   output logic [31:0] backplane_serial_out_o,
   output logic [31:0] local_serial_out_o,
   output logic [63:0] backplane_rx_byte_o,
   output logic [7:0] backplane_rx_valid_o,
   output logic [63:0] local_rx_byte_o,
   output logic [7:0] local_rx_valid_o,
   output logic [8:0] channel_o,
   output logic frame_start_o,
   output logic locked_o,
   output logic gci_mode_o,
   output logic width_err_o
);
   logic ref_prev_r;
   logic rise;
   logic fall;
   logic half_tick;
   logic tick;
   logic fp_act;
   logic start_evt;
   logic act_prev_r;
   logic idle_r;
   logic [2:0] idle_cnt_r;
   logic [1:0] run_r;
   logic [tfu_pkg::HT_BITS-1:0] hc_r;
   logic [tfu_pkg::HT_BITS-1:0] hc_nxt;
   logic [2:0] base_w;
   logic [2:0] dbl_w;
   logic [1:0] fp_w;
   logic first;

   assign rise = ref_clock_in_i && !ref_prev_r;
   assign fall = !ref_clock_in_i && ref_prev_r;
   assign half_tick = rise || fall;
   assign tick = input_edge_select_i ? rise : fall;
   // pulse is the level away from idle; meaningless until style is known
   assign fp_act = locked_o && (frame_pulse_in_i != idle_r);
   assign start_evt = tick && fp_act && !act_prev_r;
   assign base_w = pulse_width_select_i ? tfu_pkg::BASE_WIDE_HT : tfu_pkg::BASE_NARROW_HT;
   assign dbl_w = pulse_width_select_i ? tfu_pkg::DBL_WIDE_HT : tfu_pkg::DBL_NARROW_HT;
   assign fp_w = pulse_width_select_i ? tfu_pkg::FP_IN_WIDE_REF : tfu_pkg::FP_IN_NARROW_REF;
   assign first = !hc_nxt[1];
   assign gci_mode_o = !idle_r;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_prev_r <= 1'b0;
      end else begin
         ref_prev_r <= ref_clock_in_i;
      end
   end

   // style detect: a long run of one level is the idle level;
   // idle high means native active-low pulses, idle low means gci
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         idle_r <= 1'b1;
         idle_cnt_r <= 3'h0;
         locked_o <= 1'b0;
      end else if (tick) begin
         if (frame_pulse_in_i != idle_r && !locked_o) begin
            idle_r <= frame_pulse_in_i;
            idle_cnt_r <= 3'h0;
         end else if (idle_cnt_r != tfu_pkg::IDLE_LOCK_CNT) begin
            idle_cnt_r <= idle_cnt_r + 3'h1;
         end else begin
            locked_o <= 1'b1;
         end
      end
   end

   // input pulse width check, counted in reference periods
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         act_prev_r <= 1'b0;
         run_r <= 2'h0;
         width_err_o <= 1'b0;
      end else begin
         width_err_o <= 1'b0;
         if (tick) begin
            act_prev_r <= fp_act;
            if (fp_act && run_r != 2'h3) begin
               run_r <= run_r + 2'h1;
            end else if (!fp_act) begin
               run_r <= 2'h0;
               width_err_o <= act_prev_r && (run_r != fp_w);
            end
         end
      end
   end

   // frame counter in half reference periods, 2048 per 125 us frame
   always_comb begin
      hc_nxt = hc_r;
      if (start_evt) begin
         hc_nxt = '0;
      end else if (half_tick) begin
         hc_nxt = (hc_r == tfu_pkg::HT_LAST) ? '0 : hc_r + 11'h1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hc_r <= '0;
         channel_o <= 9'h000;
         frame_start_o <= 1'b0;
      end else begin
         hc_r <= hc_nxt;
         frame_start_o <= start_evt;
         if (tick) begin
            channel_o <= hc_nxt[tfu_pkg::HT_BITS-1:2];
         end
      end
   end

   // generated clocks and frame pulses; frame pulse polarity follows detected style
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         base_clock_out_o <= 1'b0;
         double_clock_out_o <= 1'b0;
         base_frame_out_o <= 1'b1;
         double_frame_out_o <= 1'b1;
      end else begin
         // inverting when the edge choices differ moves the boundary edge
         base_clock_out_o <= ref_clock_in_i ^ (input_edge_select_i ^ output_edge_select_i);
         double_clock_out_o <= half_tick;
         base_frame_out_o <= (locked_o && hc_nxt < 11'(base_w)) ? !idle_r : idle_r;
         double_frame_out_o <= (locked_o && hc_nxt < 11'(dbl_w)) ? !idle_r : idle_r;
      end
   end

   for (genvar g = 0; g < tfu_pkg::STREAMS; g++) begin : g_lane
      tfu_lane u_bp (
         .sys_clk_i(sys_clk_i),
         .nrst_i(nrst_i),
         .tick_i(tick),
         .first_i(first),
         .ser_i(backplane_serial_in_i[4*g +: 4]),
         .tx_byte_i(backplane_tx_byte_i[8*g +: 8]),
         .rx_byte_o(backplane_rx_byte_o[8*g +: 8]),
         .rx_valid_o(backplane_rx_valid_o[g]),
         .ser_o(backplane_serial_out_o[4*g +: 4])
      );
      tfu_lane u_loc (
         .sys_clk_i(sys_clk_i),
         .nrst_i(nrst_i),
         .tick_i(tick),
         .first_i(first),
         .ser_i(local_serial_in_i[4*g +: 4]),
         .tx_byte_i(local_tx_byte_i[8*g +: 8]),
         .rx_byte_o(local_rx_byte_o[8*g +: 8]),
         .rx_valid_o(local_rx_valid_o[g]),
         .ser_o(local_serial_out_o[4*g +: 4])
      );
   end

   a_frame_restart: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      start_evt |=> hc_r == '0 && frame_start_o)
      else $error("frame counter not realigned to input pulse");
   a_frame_wrap: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (half_tick && hc_r == tfu_pkg::HT_LAST) |=> hc_r == '0)
      else $error("frame counter did not wrap at 2048 half periods");
   a_edge_choice: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      tick |-> ref_clock_in_i == input_edge_select_i && $past(ref_clock_in_i) != ref_clock_in_i)
      else $error("frame tick on wrong reference edge");
   a_base_narrow: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (!pulse_width_select_i && $stable(pulse_width_select_i) && $past(hc_nxt) >= 11'h2)
      |-> base_frame_out_o == $past(idle_r))
      else $error("base frame pulse longer than two half periods");
   a_base_wide: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (pulse_width_select_i && $past(pulse_width_select_i) && $past(locked_o) && locked_o
       && $past(hc_nxt) < 11'h4) |-> base_frame_out_o == gci_mode_o)
      else $error("base frame pulse missing or wrong style");
   a_dbl_narrow: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (!pulse_width_select_i && $stable(pulse_width_select_i) && $past(hc_nxt) >= 11'h1)
      |-> double_frame_out_o == $past(idle_r))
      else $error("double frame pulse longer than one half period");
   a_dbl_wide: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (pulse_width_select_i && $past(pulse_width_select_i) && $past(locked_o) && locked_o
       && $past(hc_nxt) == 11'h1) |-> double_frame_out_o != idle_r)
      else $error("double frame pulse too short in wide mode");
   a_style_lock: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (tick && idle_cnt_r == tfu_pkg::IDLE_LOCK_CNT && !locked_o
       && frame_pulse_in_i == idle_r) |=> locked_o)
      else $error("frame style not locked after idle run");
   a_dbl_clock: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      half_tick |=> double_clock_out_o ##1 (double_clock_out_o == $past(half_tick)))
      else $error("double clock not following reference edges");
   a_width_check: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (tick && !fp_act && act_prev_r && run_r != fp_w) |=> width_err_o)
      else $error("bad input pulse width not flagged");
endmodule : tfu_timing

/* tb/tfu_src_model.sv */
// Purpose: timing source and stream senders facing the frame timing unit
// Assumes: reference clock holds each level for two system cycles
// Notes: frame pulse covers width_i reference periods from the boundary
`timescale 1ns/1ps
module tfu_src_model (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ies_i,
   input wire logic gci_i,
   input wire logic [1:0] width_i,
   input wire logic [63:0] bp_byte_i,
   input wire logic [63:0] lc_byte_i,
   output logic ref_o,
   output logic fp_o,
   output logic [31:0] bp_ser_o,
   output logic [31:0] lc_ser_o,
   output logic [11:0] phase_o
);
   logic [11:0] c_nxt;
   function automatic logic [31:0] nibs(input logic [63:0] b, input logic lo);
      logic [31:0] r;
      for (int g = 0; g < 8; g++) r[4*g +: 4] = lo ? b[8*g +: 4] : b[8*g+4 +: 4];
      return r;
   endfunction : nibs
   assign c_nxt = phase_o + 12'h001;
   // start mid-frame so style lock settles before the first pulse
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_o <= 12'h800;
         ref_o <= 1'b0;
         fp_o <= 1'b1;
         bp_ser_o <= 32'h0;
         lc_ser_o <= 32'h0;
      end else begin
         phase_o <= c_nxt;
         ref_o <= ies_i ^ c_nxt[1];
         fp_o <= ~(gci_i ^ (c_nxt < {8'h00, width_i, 2'b00}));
         bp_ser_o <= nibs(bp_byte_i, c_nxt[2]);
         lc_ser_o <= nibs(lc_byte_i, c_nxt[2]);
      end
   end
endmodule : tfu_src_model

/* tb/tdm_frame_timing_unit_tb.sv */
// Purpose: self-checking bench of the frame timing unit
// Assumes: reference period is four system cycles, frame 4096 cycles
// Notes: received bytes are checked through a queue of expected values
`timescale 1ns/1ps
module tdm_frame_timing_unit_tb;
   logic sys_clk = 1'b0, nrst = 1'b0, ies = 1'b0, oes = 1'b0, pws = 1'b0, gci = 1'b0;
   logic [1:0] w_in = 2'h1;
   logic [63:0] bp_byte = 64'h0, lc_byte = 64'h0, tx_bp = 64'h0, tx_lc = 64'h0;
   logic ref_c, fp, bco, bfo, dco, dfo, fs, lck, gmo, werr_p, armed = 1'b0, ref_q, v;
   logic [31:0] bsi, lsi, bso, lso;
   logic [63:0] brx, lrx, nb, nl;
   logic [7:0] bv, lv;
   logic [8:0] chan;
   logic [11:0] phase;
   logic [127:0] q[$];
   int n_errors = 0, n_compared = 0, n_fs, werr, cyc, t_last, dbl, run, run2;
   logic started;
   tfu_src_model src (.sys_clk_i(sys_clk), .nrst_i(nrst), .ies_i(ies), .gci_i(gci),
      .width_i(w_in), .bp_byte_i(bp_byte), .lc_byte_i(lc_byte), .ref_o(ref_c), .fp_o(fp),
      .bp_ser_o(bsi), .lc_ser_o(lsi), .phase_o(phase));
   tfu_timing uut (.sys_clk_i(sys_clk), .nrst_i(nrst), .ref_clock_in_i(ref_c),
      .frame_pulse_in_i(fp), .input_edge_select_i(ies), .output_edge_select_i(oes),
      .pulse_width_select_i(pws), .backplane_serial_in_i(bsi), .local_serial_in_i(lsi),
      .backplane_tx_byte_i(tx_bp), .local_tx_byte_i(tx_lc), .base_clock_out_o(bco),
      .base_frame_out_o(bfo), .double_clock_out_o(dco), .double_frame_out_o(dfo),
      .backplane_serial_out_o(bso), .local_serial_out_o(lso), .backplane_rx_byte_o(brx),
      .backplane_rx_valid_o(bv), .local_rx_byte_o(lrx), .local_rx_valid_o(lv),
      .channel_o(chan), .frame_start_o(fs), .locked_o(lck), .gci_mode_o(gmo),
      .width_err_o(werr_p));
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic cmp_data(input logic [127:0] got, input logic [127:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_data
   task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
      cmp_data({96'h0, got}, {96'h0, exp});
   endtask : cmp_cnt
   function automatic logic [31:0] hi(input logic [63:0] b);
      logic [31:0] r;
      for (int g = 0; g < 8; g++) r[4*g +: 4] = b[8*g+4 +: 4];
      return r;
   endfunction : hi
   task automatic conclude();
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   // new bytes one cycle before the partner starts a channel
   always @(posedge sys_clk) begin
      if (!nrst) begin
         armed = 1'b0;
         q.delete();
      end else if (phase[2:0] == 3'h6 && (armed || (phase == 12'hffe && lck === 1'b1))) begin
         armed = 1'b1;
         nb = {$urandom, $urandom};
         nl = {$urandom, $urandom};
         bp_byte <= nb;
         lc_byte <= nl;
         q.push_back({nb, nl});
      end
   end
   always @(posedge sys_clk) begin
      if (!nrst) begin
         {started, v, n_fs, werr, cyc, dbl, run, run2} = '0;
      end else begin
         cyc++;
         if (v) cmp_cnt(bco, ref_q ^ ies ^ oes);
         v = 1'b1;
         ref_q = ref_c;
         if (dco === 1'b1) dbl++;
         if (werr_p === 1'b1) werr++;
         // outputs follow idle_r, which resets high, until locked, so count only then
         if (lck === 1'b1 && bfo === gci) run++;
         else if (run != 0) begin
            cmp_cnt(run, pws ? 8 : 4);
            run = 0;
         end
         if (lck === 1'b1 && dfo === gci) run2++;
         else if (run2 != 0) begin
            cmp_cnt(run2, pws ? 4 : 2);
            run2 = 0;
         end
         if (fs === 1'b1) begin
            cmp_cnt(chan, 0);
            cmp_data({bso, lso}, {hi(tx_bp), hi(tx_lc)});
            if (started) cmp_cnt(cyc - t_last, 4096);
            if (started) cmp_cnt(dbl, 2048);
            {started, t_last, dbl} = {1'b1, cyc, 32'h0};
            n_fs++;
         end
         if ((bv | lv) !== 8'h0 && started) begin
            if (q.size() == 0) cmp_cnt(q.size(), 1);
            else cmp_data({brx, lrx}, q.pop_front());
            cmp_cnt({bv, lv}, 32'hffff);
            cmp_cnt(chan, phase[11:3]);
            // second nibble is out now; a 4-bit shift turns hi() into lo nibbles
            cmp_data({bso, lso}, {hi(tx_bp << 4), hi(tx_lc << 4)});
         end
      end
   end
   task automatic run_phase(input logic i, o, p, g, input logic [1:0] w);
      int k;
      @(posedge sys_clk);
      {nrst, ies, oes, pws, gci, w_in} <= {1'b0, i, o, p, g, w};
      {tx_bp, tx_lc} <= {$urandom, $urandom, $urandom, $urandom};
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      for (k = 0; k < 9000 && n_fs < 2; k++) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      cmp_cnt(lck, 1);
      cmp_cnt(gmo, g);
      cmp_cnt(werr != 0, w != (p ? 2'h2 : 2'h1));
   endtask : run_phase
   initial begin
      void'($urandom(9487));
      run_phase(0, 0, 0, 0, 2'h1);
      run_phase(1, 1, 1, 0, 2'h2);
      run_phase(0, 1, 0, 1, 2'h1);
      run_phase(1, 0, 1, 1, 2'h2);
      run_phase(0, 0, 0, 0, 2'h2);
      conclude();
   end
   // five phases of about 6200 cycles each
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      conclude();
   end
endmodule : tdm_frame_timing_unit_tb
